// ### verilog/rsp_serial_port.sv
// Purpose: Asynchronous serial port, one start and two stop bits
// Assumes: Single 125 MHz clock, line from a pin
// Notes:   Settings are sampled when each frame starts
//
// Operation
// R1 - Ten rates from 300 to 115200 baud, shared by send and receive.
// R2 - Rate defaults to 9600 baud after reset.
// R3 - Formats: none/8 bits default, even/7 bits, odd/7 bits.
// R4 - Each frame starts with exactly one start bit.
// R5 - Each sent frame ends with exactly two stop bits.
// R6 - Host uses the same rate, parity and data width.
// R7 - Host frames with one start bit and two stop bits.
// R8 - Line idles at mark, LSB first, parity over seven bits before stops.
`include "rsp_cfg.svh"

module rsp_serial_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Settings
    input wire logic [3:0] rateSel,
    input wire logic rateSelValid,
    input wire logic [1:0] fmtSel,
    input wire logic fmtSelValid,
    // Transmit stream
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    // Receive stream
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxParityErr,
    output logic rxFrameErr,
    // Serial line
    input wire logic serialIn,
    output logic serialOut
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Rate code to cycles per bit; unknown codes fall back to 9600
    function automatic logic [`RSP_DIV_W-1:0] bitDiv(input logic [3:0] code);
        case (code)
            4'h0: bitDiv = `RSP_DIV_W'(`RSP_DIV_300);
            4'h1: bitDiv = `RSP_DIV_W'(`RSP_DIV_600);
            4'h2: bitDiv = `RSP_DIV_W'(`RSP_DIV_1200);
            4'h3: bitDiv = `RSP_DIV_W'(`RSP_DIV_2400);
            4'h4: bitDiv = `RSP_DIV_W'(`RSP_DIV_4800);
            4'h6: bitDiv = `RSP_DIV_W'(`RSP_DIV_19200);
            4'h7: bitDiv = `RSP_DIV_W'(`RSP_DIV_38400);
            4'h8: bitDiv = `RSP_DIV_W'(`RSP_DIV_57600);
            4'h9: bitDiv = `RSP_DIV_W'(`RSP_DIV_115200);
            default: bitDiv = `RSP_DIV_W'(`RSP_DIV_9600);
        endcase
    endfunction

    // Data bits per format: eight without parity, seven with
    function automatic logic [3:0] dataBits(input rsp_pkg::rsp_fmt_e f);
        dataBits = (f == rsp_pkg::RSP_FMT_N8) ? 4'h8 : 4'h7;
    endfunction

    // Parity bit for a seven bit character
    function automatic logic parBit(input rsp_pkg::rsp_fmt_e f, input logic [6:0] d);
        parBit = (f == rsp_pkg::RSP_FMT_O7) ? ~(^d) : (^d);
    endfunction

    // ************************************************************
    // Settings
    // ************************************************************

    logic [3:0] rate_q, rate_d;
    rsp_pkg::rsp_fmt_e fmt_q, fmt_d;

    // Codes above nine and unused format code are ignored
    always_comb begin
        rate_d = rate_q;
        fmt_d = fmt_q;
        if (rateSelValid && rateSel <= 4'h9) begin
            rate_d = rateSel; // [R1]
        end
        if (fmtSelValid && fmtSel != 2'h3) begin
            fmt_d = rsp_pkg::rsp_fmt_e'(fmtSel); // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rate_q <= `RSP_RATE_DEFAULT; // [R2]
            fmt_q <= rsp_pkg::rsp_fmt_e'(`RSP_FMT_DEFAULT); // [R3]
        end else begin
            rate_q <= rate_d;
            fmt_q <= fmt_d;
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************

    rsp_pkg::rsp_tx_e txSt_q, txSt_d;
    logic [`RSP_DIV_W-1:0] txCnt_q, txCnt_d, txDiv_q, txDiv_d;
    logic [7:0] txSh_q, txSh_d;
    logic [3:0] txBit_q, txBit_d;
    logic [3:0] txNb_q, txNb_d;
    logic txPar_q, txPar_d;
    logic serialOut_d, txReady_d;
    logic txTick;

    assign txTick = (txCnt_q == `RSP_DIV_W'(1));

    // Frame sequencer; settings latched at frame start so a change
    // mid-frame cannot corrupt the character on the line
    always_comb begin
        txSt_d = txSt_q;
        txCnt_d = txTick ? txDiv_q : txCnt_q - `RSP_DIV_W'(1);
        txDiv_d = txDiv_q;
        txSh_d = txSh_q;
        txBit_d = txBit_q;
        txNb_d = txNb_q;
        txPar_d = txPar_q;
        serialOut_d = serialOut;
        txReady_d = 1'b0;
        case (txSt_q)
            rsp_pkg::RSP_TX_IDLE: begin
                serialOut_d = 1'b1; // [R8]
                txReady_d = 1'b1;
                if (txValid && txReady) begin
                    txDiv_d = bitDiv(rate_q); // [R1]
                    txCnt_d = bitDiv(rate_q);
                    txSh_d = txData;
                    txNb_d = dataBits(fmt_q);
                    txPar_d = (fmt_q != rsp_pkg::RSP_FMT_N8);
                    txSh_d[7] = (fmt_q == rsp_pkg::RSP_FMT_N8) ? txData[7]
                                : parBit(fmt_q, txData[6:0]); // [R8]
                    serialOut_d = 1'b0; // [R4]
                    txReady_d = 1'b0;
                    txBit_d = 4'h0;
                    txSt_d = rsp_pkg::RSP_TX_START;
                end
            end
            rsp_pkg::RSP_TX_START: begin
                if (txTick) begin
                    serialOut_d = txSh_q[0]; // [R8]
                    txSt_d = rsp_pkg::RSP_TX_DATA;
                end
            end
            rsp_pkg::RSP_TX_DATA: begin
                if (txTick) begin
                    txBit_d = txBit_q + 4'h1;
                    txSh_d = {1'b0, txSh_q[7:1]};
                    if (txBit_q + 4'h1 == txNb_q) begin
                        // Parity was loaded in bit 7; six shifts leave it in bit 1
                        serialOut_d = txPar_q ? txSh_q[1] : 1'b1; // [R8]
                        txBit_d = 4'h0;
                        txSt_d = txPar_q ? rsp_pkg::RSP_TX_PAR : rsp_pkg::RSP_TX_STOP;
                    end else begin
                        serialOut_d = txSh_q[1];
                    end
                end
            end
            rsp_pkg::RSP_TX_PAR: begin
                if (txTick) begin
                    serialOut_d = 1'b1;
                    txSt_d = rsp_pkg::RSP_TX_STOP;
                end
            end
            rsp_pkg::RSP_TX_STOP: begin
                serialOut_d = 1'b1;
                if (txTick) begin
                    txBit_d = txBit_q + 4'h1;
                    if (txBit_q + 4'h1 == 4'(`RSP_STOP_BITS)) begin
                        txSt_d = rsp_pkg::RSP_TX_IDLE; // [R5]
                    end
                end
            end
            default: txSt_d = rsp_pkg::RSP_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txSt_q <= rsp_pkg::RSP_TX_IDLE;
            txCnt_q <= `RSP_DIV_W'(1);
            txDiv_q <= `RSP_DIV_W'(1);
            txSh_q <= 8'h00;
            txBit_q <= 4'h0;
            txNb_q <= 4'h8;
            txPar_q <= 1'b0;
            serialOut <= 1'b1; // [R8]
            txReady <= 1'b0;
        end else begin
            txSt_q <= txSt_d;
            txCnt_q <= txCnt_d;
            txDiv_q <= txDiv_d;
            txSh_q <= txSh_d;
            txBit_q <= txBit_d;
            txNb_q <= txNb_d;
            txPar_q <= txPar_d;
            serialOut <= serialOut_d;
            txReady <= txReady_d;
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************

    logic [2:0] rxSync_q, rxSync_d;
    logic rxLine_q, rxLine_d;

    // Three stage synchroniser; level accepted when stages two and three agree
    always_comb begin
        rxSync_d = {rxSync_q[1:0], serialIn};
        rxLine_d = (rxSync_q[1] == rxSync_q[2]) ? rxSync_q[2] : rxLine_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxSync_q <= 3'h7;
            rxLine_q <= 1'b1;
        end else begin
            rxSync_q <= rxSync_d;
            rxLine_q <= rxLine_d;
        end
    end

    rsp_pkg::rsp_rx_e rxSt_q, rxSt_d;
    logic [`RSP_DIV_W-1:0] rxCnt_q, rxCnt_d, rxDiv_q, rxDiv_d;
    logic [7:0] rxSh_q, rxSh_d;
    logic [3:0] rxBit_q, rxBit_d, rxNb_q, rxNb_d;
    rsp_pkg::rsp_fmt_e rxFmt_q, rxFmt_d;
    logic [7:0] rxData_d;
    logic rxValid_d, rxParityErr_d, rxFrameErr_d, rxPerr_q, rxPerr_d;
    logic rxTick;

    assign rxTick = (rxCnt_q == `RSP_DIV_W'(1));

    // Samples mid-bit; only the first stop bit is checked so a host
    // sending one stop bit is still received
    always_comb begin
        rxSt_d = rxSt_q;
        rxCnt_d = rxTick ? rxDiv_q : rxCnt_q - `RSP_DIV_W'(1);
        rxDiv_d = rxDiv_q;
        rxSh_d = rxSh_q;
        rxBit_d = rxBit_q;
        rxNb_d = rxNb_q;
        rxFmt_d = rxFmt_q;
        rxPerr_d = rxPerr_q;
        rxData_d = rxData;
        rxValid_d = 1'b0;
        rxParityErr_d = rxParityErr;
        rxFrameErr_d = rxFrameErr;
        case (rxSt_q)
            rsp_pkg::RSP_RX_IDLE: begin
                if (!rxLine_q) begin
                    rxDiv_d = bitDiv(rate_q); // [R1]
                    rxCnt_d = bitDiv(rate_q) >> 1;
                    rxFmt_d = fmt_q;
                    rxNb_d = dataBits(fmt_q); // [R3]
                    rxSh_d = 8'h00;
                    rxBit_d = 4'h0;
                    rxSt_d = rsp_pkg::RSP_RX_START;
                end
            end
            rsp_pkg::RSP_RX_START: begin
                if (rxTick) begin
                    // Glitch shorter than half a bit is dropped
                    rxSt_d = rxLine_q ? rsp_pkg::RSP_RX_IDLE : rsp_pkg::RSP_RX_DATA; // [R4]
                end
            end
            rsp_pkg::RSP_RX_DATA: begin
                if (rxTick) begin
                    rxSh_d[rxBit_q[2:0]] = rxLine_q; // [R8]
                    rxBit_d = rxBit_q + 4'h1;
                    if (rxBit_q + 4'h1 == rxNb_q) begin
                        rxSt_d = (rxFmt_q == rsp_pkg::RSP_FMT_N8)
                                 ? rsp_pkg::RSP_RX_STOP : rsp_pkg::RSP_RX_PAR;
                    end
                end
            end
            rsp_pkg::RSP_RX_PAR: begin
                if (rxTick) begin
                    rxPerr_d = (rxLine_q != parBit(rxFmt_q, rxSh_q[6:0])); // [R8]
                    rxSt_d = rsp_pkg::RSP_RX_STOP;
                end
            end
            rsp_pkg::RSP_RX_STOP: begin
                if (rxTick) begin
                    rxData_d = rxSh_q;
                    rxValid_d = 1'b1;
                    rxParityErr_d = (rxFmt_q != rsp_pkg::RSP_FMT_N8) && rxPerr_q;
                    rxFrameErr_d = !rxLine_q;
                    rxPerr_d = 1'b0;
                    rxSt_d = rsp_pkg::RSP_RX_IDLE;
                end
            end
            default: rxSt_d = rsp_pkg::RSP_RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxSt_q <= rsp_pkg::RSP_RX_IDLE;
            rxCnt_q <= `RSP_DIV_W'(1);
            rxDiv_q <= `RSP_DIV_W'(1);
            rxSh_q <= 8'h00;
            rxBit_q <= 4'h0;
            rxNb_q <= 4'h8;
            rxFmt_q <= rsp_pkg::RSP_FMT_N8;
            rxPerr_q <= 1'b0;
            rxData <= 8'h00;
            rxValid <= 1'b0;
            rxParityErr <= 1'b0;
            rxFrameErr <= 1'b0;
        end else begin
            rxSt_q <= rxSt_d;
            rxCnt_q <= rxCnt_d;
            rxDiv_q <= rxDiv_d;
            rxSh_q <= rxSh_d;
            rxBit_q <= rxBit_d;
            rxNb_q <= rxNb_d;
            rxFmt_q <= rxFmt_d;
            rxPerr_q <= rxPerr_d;
            rxData <= rxData_d;
            rxValid <= rxValid_d;
            rxParityErr <= rxParityErr_d;
            rxFrameErr <= rxFrameErr_d;
        end
    end

endmodule

// ### verilog/rsp_cfg.svh
// Purpose: Constants for the serial port block
// Assumes: 125 MHz system clock
// Notes:   Divisors are clock cycles per bit, rounded down
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

`define RSP_CLK_HZ 125000000
`define RSP_DIV_W 19
// Cycles per bit for each selectable rate
`define RSP_DIV_300 (`RSP_CLK_HZ / 300)
`define RSP_DIV_600 (`RSP_CLK_HZ / 600)
`define RSP_DIV_1200 (`RSP_CLK_HZ / 1200)
`define RSP_DIV_2400 (`RSP_CLK_HZ / 2400)
`define RSP_DIV_4800 (`RSP_CLK_HZ / 4800)
`define RSP_DIV_9600 (`RSP_CLK_HZ / 9600)
`define RSP_DIV_19200 (`RSP_CLK_HZ / 19200)
`define RSP_DIV_38400 (`RSP_CLK_HZ / 38400)
`define RSP_DIV_57600 (`RSP_CLK_HZ / 57600)
`define RSP_DIV_115200 (`RSP_CLK_HZ / 115200)
// Frame shape
`define RSP_STOP_BITS 2
`define RSP_RATE_DEFAULT 4'h5
`define RSP_FMT_DEFAULT 2'h0

`endif

// ### verilog/rsp_pkg.sv
// Purpose: Types for the serial port block
// Assumes: Nothing beyond the constants header
// Notes:   Rate codes 0..9 run from 300 to 115200 baud
package rsp_pkg;
    // Character format pairing
    typedef enum logic [1:0] {
        RSP_FMT_N8,
        RSP_FMT_E7,
        RSP_FMT_O7
    } rsp_fmt_e;
    // Transmit sequencer
    typedef enum logic [2:0] {
        RSP_TX_IDLE,
        RSP_TX_START,
        RSP_TX_DATA,
        RSP_TX_PAR,
        RSP_TX_STOP
    } rsp_tx_e;
    // Receive sequencer
    typedef enum logic [2:0] {
        RSP_RX_IDLE,
        RSP_RX_START,
        RSP_RX_DATA,
        RSP_RX_PAR,
        RSP_RX_STOP
    } rsp_rx_e;
endpackage

// ### verif/rsp_host_model.sv
// Purpose: Host terminal side that sends characters to the port
// Assumes: Caller gives cycles per bit and format
// Notes: Can spoil parity or the first stop bit on request
module rsp_host_model (
    // Clock
    input wire logic clk_sys,
    // Line toward the port
    output logic serialLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line rests at mark between frames
    initial serialLine = 1'b1;
    // One frame; bit times locked to the clock so sampling never sits on an edge
    task automatic sendChar(input logic [7:0] d, input logic [1:0] fmt, input int dv,
        input logic badPar, input logic badStop);
        logic [10:0] f;
        logic p;
        p = ((fmt == rsp_pkg::RSP_FMT_E7) ? ^d[6:0] : ~^d[6:0]) ^ badPar;
        f = (fmt == rsp_pkg::RSP_FMT_N8) ? {2'b11, d, 1'b0} : {2'b11, p, d[6:0], 1'b0};
        f[9] = f[9] & ~badStop;
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            serialLine <= f[i]; // Start, then LSB first
            repeat (dv) @(posedge clk_sys);
        end
    endtask
endmodule

// ### verif/rsp_serial_port_chk.sv
// Purpose: Pin-level assertions on the serial port
// Assumes: Settings are not loaded on the edge that takes a character
// Notes: Shadows rate and format to time each sent bit
`include "rsp_cfg.svh"
module rsp_serial_port_chk (
    // Clock, reset and settings
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] rateSel,
    input wire logic rateSelValid,
    input wire logic [1:0] fmtSel,
    input wire logic fmtSelValid,
    // Streams and line
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxParityErr,
    input wire logic rxFrameErr,
    input wire logic serialIn,
    input wire logic serialOut
);
    localparam int RATE[10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    int divQ, divD, cntQ, cntD, idx;
    logic [3:0] rateQ, rateD;
    logic [1:0] fmtQ, fmtD, fmtLQ, fmtLD;
    logic [7:0] datQ, datD;
    logic take, expBit, midBit;
    // Shadow settings; a frame keeps what was set when it was taken
    always_comb begin
        take = txValid && txReady;
        rateD = (rateSelValid && rateSel <= 4'h9) ? rateSel : rateQ;
        fmtD = (fmtSelValid && fmtSel != 2'h3) ? fmtSel : fmtQ;
        divD = take ? `RSP_CLK_HZ / RATE[rateQ] : divQ;
        fmtLD = take ? fmtQ : fmtLQ;
        datD = take ? txData : datQ;
        cntD = take ? 1 : (txReady || cntQ == 0) ? 0 : cntQ + 1;
        idx = (cntQ - 1) / divQ - 1;
        midBit = cntQ > divQ && cntQ <= 9 * divQ && (cntQ - 1) % divQ == divQ / 2;
        expBit = (idx < 7 || fmtLQ == rsp_pkg::RSP_FMT_N8) ? datQ[idx[2:0]] :
            (fmtLQ == rsp_pkg::RSP_FMT_E7) ? ^datQ[6:0] : ~^datQ[6:0];
    end
    // Divider starts at one so the bit index never divides by zero
    always_ff @(posedge clk_sys) begin
        rateQ <= rst_n ? rateD : `RSP_RATE_DEFAULT;
        fmtQ <= rst_n ? fmtD : `RSP_FMT_DEFAULT;
        divQ <= rst_n ? divD : 1;
        cntQ <= rst_n ? cntD : 0;
        fmtLQ <= fmtLD;
        datQ <= datD;
    end
    //****************************************
    // Assertions
    //****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_take; txValid && txReady; endsequence
    sequence s_startBit; !serialOut && !txReady; endsequence
    property p_rstIdle; $rose(rst_n) |-> serialOut && !txReady && !rxValid && rxData == 8'h00; endproperty
    a_rstIdle: assert property (p_rstIdle) else $error("outputs not idle after reset");
    property p_takeStart; s_take |=> s_startBit; endproperty
    a_takeStart: assert property (p_takeStart) else $error("no start bit after take");
    property p_startLow; cntQ >= 1 && cntQ <= divQ |-> !serialOut; endproperty
    a_startLow: assert property (p_startLow) else $error("start bit too short");
    property p_dataBit; midBit |-> serialOut == expBit; endproperty
    a_dataBit: assert property (p_dataBit) else $error("wrong data or parity bit");
    property p_stopHigh; cntQ > 9 * divQ && cntQ <= 11 * divQ |-> serialOut; endproperty
    a_stopHigh: assert property (p_stopHigh) else $error("stop bits not high");
    property p_frameLen; $rose(txReady) && cntQ != 0 |-> cntQ inside {[11 * divQ + 1:11 * divQ + 2]}; endproperty
    a_frameLen: assert property (p_frameLen) else $error("frame length wrong");
    property p_busy; cntQ >= 1 && cntQ <= 11 * divQ |-> !txReady; endproperty
    a_busy: assert property (p_busy) else $error("ready during frame");
    property p_rxPulse; rxValid |=> !rxValid [*2]; endproperty
    a_rxPulse: assert property (p_rxPulse) else $error("receive pulse too long");
    property p_rxFmt; rxValid |-> (fmtQ == rsp_pkg::RSP_FMT_N8) ? !rxParityErr : !rxData[7]; endproperty
    a_rxFmt: assert property (p_rxFmt) else $error("receive format wrong");
endmodule
bind rsp_serial_port rsp_serial_port_chk rsp_serial_port_chk_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .rateSel(rateSel), .rateSelValid(rateSelValid), .fmtSel(fmtSel),
    .fmtSelValid(fmtSelValid), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr),
    .serialIn(serialIn), .serialOut(serialOut));

// ### verif/tb_rsp_serial_port.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Host model alone drives the receive line
// Notes: Probes 9600 by one start bit only, then runs at 115200
`include "rsp_cfg.svh"
module tb_rsp_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = `RSP_DIV_115200;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] rateSel = 4'h0;
    logic [1:0] fmtSel = 2'h0;
    logic [7:0] txData = 8'h00;
    logic rateSelValid = 1'b0;
    logic fmtSelValid = 1'b0;
    logic txValid = 1'b0;
    logic txReady, rxValid, rxParityErr, rxFrameErr, serialIn, serialOut, gotPe, gotFe;
    logic [7:0] rxData, gotData;
    int n_fail = 0;
    int checked = 0;
    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;
    rsp_serial_port rsp_serial_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .rateSel(rateSel),
        .rateSelValid(rateSelValid), .fmtSel(fmtSel), .fmtSelValid(fmtSelValid),
        .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr),
        .serialIn(serialIn), .serialOut(serialOut));
    rsp_host_model rsp_host_model_inst (.clk_sys(clk_sys), .serialLine(serialIn));
    // Keep the last character the port delivered
    always @(posedge clk_sys) begin
        if (rxValid === 1'b1) begin
            gotData <= rxData;
            gotPe <= rxParityErr;
            gotFe <= rxFrameErr;
        end
    end
    //****************************************
    // Helper tasks
    //****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic doReset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic setCfg(input logic [3:0] r, input logic [1:0] f);
        @(posedge clk_sys);
        rateSel <= r;
        fmtSel <= f;
        rateSelValid <= 1'b1;
        fmtSelValid <= 1'b1;
        @(posedge clk_sys);
        rateSelValid <= 1'b0;
        fmtSelValid <= 1'b0;
    endtask
    // Offer a character and hold it until the edge that takes it
    task automatic sendTx(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        txData <= d;
        txValid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (txReady !== 1'b1 && n < 200000);
        txValid <= 1'b0;
    endtask
    // Default rate seen as start bit width; reset cuts the frame short to save time
    task automatic t_default();
        int n;
        n = 0;
        sendTx(8'h55);
        @(posedge clk_sys);
        while (serialOut === 1'b0 && n < 20000) begin
            n++;
            @(posedge clk_sys);
        end
        chk("start bit cycles", n[15:0], 16'(`RSP_DIV_9600));
        doReset();
        chk("line after reset", {15'h0, serialOut}, 16'h1);
        $display("t_default done");
    endtask
    // Every format both ways at once; checker times the sent bits
    task automatic t_formats();
        for (int f = 0; f < 3; f++) begin
            setCfg(4'h9, f[1:0]);
            fork
                sendTx(8'ha5 ^ f[7:0]);
                rsp_host_model_inst.sendChar(8'hc3 ^ f[7:0], f[1:0], D, 1'b0, 1'b0);
            join
            chk("rx char", {8'h0, gotData}, (f == 0) ? 16'hc3 : 16'h7f & (16'hc3 ^ 16'(f)));
            chk("rx flags", {14'h0, gotPe, gotFe}, 16'h0);
        end
        $display("t_formats done");
    endtask
    // Bad codes ignored, back-to-back sends, then spoiled parity and stop bit
    task automatic t_refuse();
        setCfg(4'hc, 2'h3);
        fork
            begin
                sendTx(8'h81);
                sendTx(8'h7e);
            end
            rsp_host_model_inst.sendChar(8'hbc, 2'h2, D, 1'b0, 1'b0);
        join
        chk("rx odd char", {8'h0, gotData}, 16'h3c);
        rsp_host_model_inst.sendChar(8'h11, 2'h2, D, 1'b1, 1'b0);
        chk("parity error", {15'h0, gotPe}, 16'h1);
        rsp_host_model_inst.sendChar(8'h22, 2'h2, D, 1'b0, 1'b1);
        chk("frame error", {15'h0, gotFe}, 16'h1);
        $display("t_refuse done");
    endtask
    initial begin
        doReset();
        t_default();
        t_formats();
        t_refuse();
        finish_test();
    end
    // About 85k cycles of tests, so this limit leaves about three quarters again as margin
    initial begin
        repeat (150000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end
endmodule
